// *** logic/line_power_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

// Function
// - A low force-shutdown input turns every driver off while receivers stay on.
// - High force-active with high force-shutdown keeps the drivers on.
// - In automatic mode the drivers stay on while an edge came within 30 s.
// - In automatic mode the drivers shut down after 30 s without any edge.
// - With force-active tied to line validity, a valid level or recent edge keeps drivers on.
// - With both force inputs tied to line validity, drivers follow validity alone.
// - On leaving shutdown, drivers wait for the negative supply to be good.
// - The valid-level output shows receiver line validity and nothing else.
// - After an idle shutdown any receiver or driver input edge wakes the drivers.
module line_power_ctrl #(
  parameter logic [35:0] IDLE_CYCLES = 36'(line_power_pkg::IDLE_CYCLES),
  parameter int          LANES       = 3
) (
  input  wire logic             CLK,
  input  wire logic             RESETN,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [7:0]       PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  input  wire logic [LANES-1:0] RX_IN,
  input  wire logic [LANES-1:0] RX_LEVEL_OK,
  input  wire logic [LANES-1:0] TX_IN,
  input  wire logic             FORCE_ACTIVE_IN,
  input  wire logic             FORCE_SHUTDOWN_N,
  input  wire logic             NEG_SUPPLY_OK,
  output logic      [LANES-1:0] RX_OUT,
  output logic      [LANES-1:0] TX_OUT,
  output logic      [LANES-1:0] TX_OE,
  output logic                  PUMP_EN,
  output logic                  VALID_OUT,
  output logic                  IRQ
);

  localparam int SW = 3 * LANES + 3;
  localparam int TX_LO = LANES;
  localparam int LV_LO = 2 * LANES;
  localparam int FA_BIT = 3 * LANES;
  localparam int FS_BIT = 3 * LANES + 1;
  localparam int SUP_BIT = 3 * LANES + 2;
  localparam int EVW = line_power_pkg::EV_WIDTH;
  localparam int CW = line_power_pkg::IDLE_CNT_WIDTH;

  initial begin
    if (IDLE_CYCLES < 36'h2) $error("idle window too short");
    if (LANES < 1 || LANES > 8) $error("lane count out of range");
  end

  function automatic logic addr_known(input logic [7:0] a);
    if (a == line_power_pkg::CTRL_ADDR) addr_known = 1'b1;
    else if (a == line_power_pkg::STATUS_ADDR) addr_known = 1'b1;
    else if (a == line_power_pkg::IRQ_STATUS_ADDR) addr_known = 1'b1;
    else if (a == line_power_pkg::IRQ_ENABLE_ADDR) addr_known = 1'b1;
    else if (a == line_power_pkg::IRQ_CLEAR_ADDR) addr_known = 1'b1;
    else addr_known = 1'b0;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SW-1:0] pin_level;
  logic [SW-1:0] pin_change;

  pin_sync #(.WIDTH(SW)) u_sync (
    .clk    (CLK),
    .resetn (RESETN),
    .pin    ({NEG_SUPPLY_OK, FORCE_SHUTDOWN_N, FORCE_ACTIVE_IN,
              RX_LEVEL_OK, TX_IN, RX_IN}),
    .level  (pin_level),
    .change (pin_change)
  );

  logic [LANES-1:0] rx_now;
  logic [LANES-1:0] tx_now;
  logic             line_valid;
  logic             any_edge;
  logic             supply_ok;

  assign rx_now     = pin_level[LANES-1:0];
  assign tx_now     = pin_level[TX_LO +: LANES];
  assign line_valid = |pin_level[LV_LO +: LANES];
  assign supply_ok  = pin_level[SUP_BIT];
  // only data edges count as activity, not level or control pins
  assign any_edge   = |pin_change[2*LANES-1:0];

  //////////////////////////////////////////////////////////////////////////
  // registers written by software

  logic [3:0]     ctrl;
  logic [3:0]     next_ctrl;
  logic [EVW-1:0] irq_enable;
  logic [EVW-1:0] next_irq_enable;
  logic [31:0]    next_prdata;
  logic           apb_write;
  logic           apb_setup;

  assign apb_write = PSEL && PENABLE && PWRITE;
  assign apb_setup = PSEL && !PENABLE;
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && !addr_known(PADDR);

  logic           link_active;
  logic           link_shutdown;
  logic           sw_mode;
  logic           fa_eff;
  logic           fs_eff;

  assign link_active   = ctrl[line_power_pkg::CTRL_LINK_ACTIVE_BIT];
  assign link_shutdown = ctrl[line_power_pkg::CTRL_LINK_SHUTDOWN_BIT];
  assign sw_mode       = ctrl[line_power_pkg::CTRL_SW_MODE_BIT];

  //////////////////////////////////////////////////////////////////////////
  // inactivity timer

  logic [CW-1:0] idle_count;
  logic [CW-1:0] next_idle_count;
  logic          idle_expired;
  logic          next_idle_expired;

  always_comb begin
    next_idle_count   = idle_count;
    next_idle_expired = idle_expired;
    if (any_edge) begin
      next_idle_count   = '0;
      next_idle_expired = 1'b0;
    end else if (!idle_expired) begin
      if (idle_count == IDLE_CYCLES - 36'h1) begin
        next_idle_expired = 1'b1;
      end else begin
        next_idle_count = idle_count + 36'h1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      idle_count   <= '0;
      idle_expired <= 1'b0;
    end else begin
      idle_count   <= next_idle_count;
      idle_expired <= next_idle_expired;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // driver power decision

  line_power_pkg::drv_state_t state;
  line_power_pkg::drv_state_t next_state;
  logic                       want_on;
  logic [LANES-1:0]           next_tx_oe;

  always_comb begin
    // software mode stands in for both force pins tied together
    if (sw_mode) begin
      fa_eff = ctrl[line_power_pkg::CTRL_SW_SHUTDOWN_N_BIT];
      fs_eff = ctrl[line_power_pkg::CTRL_SW_SHUTDOWN_N_BIT];
    end else begin
      fa_eff = link_active ? line_valid : pin_level[FA_BIT];
      fs_eff = link_shutdown ? line_valid : pin_level[FS_BIT];
    end
    if (!fs_eff) want_on = 1'b0;
    else if (fa_eff) want_on = 1'b1;
    else want_on = !idle_expired;
    next_state = state;
    case (state)
      line_power_pkg::DRV_OFF: begin
        if (want_on) next_state = line_power_pkg::DRV_PUMPING;
      end
      line_power_pkg::DRV_PUMPING: begin
        if (!want_on) next_state = line_power_pkg::DRV_OFF;
        else if (supply_ok) next_state = line_power_pkg::DRV_ON;
      end
      line_power_pkg::DRV_ON: begin
        if (!want_on) next_state = line_power_pkg::DRV_OFF;
      end
      default: next_state = line_power_pkg::DRV_OFF;
    endcase
    next_tx_oe = {LANES{next_state == line_power_pkg::DRV_ON}};
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state     <= line_power_pkg::DRV_OFF;
      TX_OE     <= '0;
      PUMP_EN   <= 1'b0;
      TX_OUT    <= '0;
      RX_OUT    <= '0;
      VALID_OUT <= 1'b0;
    end else begin
      state     <= next_state;
      TX_OE     <= next_tx_oe;
      PUMP_EN   <= next_state != line_power_pkg::DRV_OFF;
      TX_OUT    <= ~tx_now;                 // drivers invert
      RX_OUT    <= ~rx_now;
      VALID_OUT <= line_valid;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupts and register file

  logic [EVW-1:0] irq_status;
  logic [EVW-1:0] next_irq_status;
  logic [EVW-1:0] events;
  logic [EVW-1:0] clear_mask;
  localparam int STATW = line_power_pkg::STAT_WIDTH;
  logic [STATW-1:0] status_word;

  always_comb begin
    events = '0;
    events[line_power_pkg::EV_DRIVERS_ON_BIT]  = next_tx_oe[0] && !TX_OE[0];
    events[line_power_pkg::EV_DRIVERS_OFF_BIT] = !next_tx_oe[0] && TX_OE[0];
    events[line_power_pkg::EV_IDLE_BIT]  = next_idle_expired && !idle_expired;
    events[line_power_pkg::EV_VALID_BIT] = line_valid != VALID_OUT;
    clear_mask = '0;
    if (apb_write && PADDR == line_power_pkg::IRQ_CLEAR_ADDR)
      clear_mask = PWDATA[EVW-1:0];
    // a new event outweighs a clear in the same cycle
    next_irq_status = (irq_status & ~clear_mask) | events;
    next_ctrl       = ctrl;
    next_irq_enable = irq_enable;
    if (apb_write && PADDR == line_power_pkg::CTRL_ADDR)
      next_ctrl = PWDATA[line_power_pkg::CTRL_WIDTH-1:0];
    else if (apb_write && PADDR == line_power_pkg::IRQ_ENABLE_ADDR)
      next_irq_enable = PWDATA[EVW-1:0];
    status_word = '0;
    status_word[line_power_pkg::STAT_DRIVERS_ON_BIT] = TX_OE[0];
    status_word[line_power_pkg::STAT_PUMP_BIT]       = PUMP_EN;
    status_word[line_power_pkg::STAT_LINE_VALID_BIT] = line_valid;
    status_word[line_power_pkg::STAT_IDLE_BIT]       = idle_expired;
    status_word[line_power_pkg::STAT_SUPPLY_OK_BIT]  = supply_ok;
    // read data is caught in the setup cycle, zero wait states
    next_prdata = PRDATA;
    if (apb_setup && !PWRITE) begin
      if (PADDR == line_power_pkg::CTRL_ADDR)
        next_prdata = {28'h0000000, ctrl};
      else if (PADDR == line_power_pkg::STATUS_ADDR)
        next_prdata = {27'h0000000, status_word};
      else if (PADDR == line_power_pkg::IRQ_STATUS_ADDR)
        next_prdata = {28'h0000000, irq_status};
      else if (PADDR == line_power_pkg::IRQ_ENABLE_ADDR)
        next_prdata = {28'h0000000, irq_enable};
      else
        next_prdata = 32'h00000000;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl       <= line_power_pkg::CTRL_RESET;
      irq_enable <= line_power_pkg::IRQ_ENABLE_RESET;
      irq_status <= '0;
      PRDATA     <= '0;
      IRQ        <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      irq_enable <= next_irq_enable;
      irq_status <= next_irq_status;
      PRDATA     <= next_prdata;
      IRQ        <= |(next_irq_status & next_irq_enable);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_forced_off_hiz: assert property (
    !fs_eff |=> (TX_OE == '0) && !PUMP_EN)
    else $error("drivers on while forced off");

  a_rx_always_live: assert property (
    $past(RESETN) |-> RX_OUT == ~$past(rx_now))
    else $error("receiver output not following line");

  a_forced_on_keep: assert property (
    fs_eff && fa_eff |=> PUMP_EN)
    else $error("pump off while forced on");

  a_recent_edge_on: assert property (
    fs_eff && !fa_eff && !idle_expired |=> PUMP_EN)
    else $error("drivers off despite recent edge");

  a_idle_shutdown: assert property (
    fs_eff && !fa_eff && idle_expired |=> !PUMP_EN && (TX_OE == '0))
    else $error("drivers on after idle window");

  a_valid_keeps_on: assert property (
    !sw_mode && link_active && !link_shutdown && pin_level[FS_BIT]
      && line_valid |=> PUMP_EN)
    else $error("valid level did not keep drivers on");

  a_level_only: assert property (
    !sw_mode && link_active && link_shutdown && !line_valid
      |=> !PUMP_EN)
    else $error("drivers on without valid level");

  a_software_line: assert property (
    sw_mode && ctrl[line_power_pkg::CTRL_SW_SHUTDOWN_N_BIT] |=> PUMP_EN)
    else $error("software line did not force drivers on");

  a_supply_gate: assert property (
    $rose(TX_OE[0]) |-> $past(supply_ok)
      && $past(state) != line_power_pkg::DRV_OFF)
    else $error("drivers enabled before supply was good");

  a_valid_output: assert property (
    $past(RESETN) |-> VALID_OUT == $past(line_valid))
    else $error("valid output lost track of line");

  a_edge_wakes: assert property (
    any_edge && idle_expired |=> !idle_expired ##0 idle_count == '0)
    else $error("edge did not restart idle timer");

  a_timer_full: assert property (
    $rose(idle_expired) |-> $past(idle_count) == IDLE_CYCLES - 36'h1)
    else $error("idle timer expired early");

  a_set_beats_clear: assert property (
    events[line_power_pkg::EV_IDLE_BIT] |=>
      irq_status[line_power_pkg::EV_IDLE_BIT])
    else $error("idle event lost");

  c_forced_off: cover property (PUMP_EN ##1 !fs_eff ##1 !PUMP_EN);
  c_idle_expiry: cover property ($rose(idle_expired));
  c_idle_wake: cover property (idle_expired ##1 any_edge ##[1:8] PUMP_EN);
  c_supply_wait: cover property (
    state == line_power_pkg::DRV_PUMPING [*3] ##1 TX_OE[0]);

endmodule

`default_nettype wire

// *** logic/line_power_pkg.sv ***
package line_power_pkg;

  // register byte addresses
  localparam logic [7:0] CTRL_ADDR       = 8'h00;
  localparam logic [7:0] STATUS_ADDR     = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h08;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h0C;
  localparam logic [7:0] IRQ_CLEAR_ADDR  = 8'h10;

  // control register fields
  localparam int CTRL_LINK_ACTIVE_BIT   = 0;
  localparam int CTRL_LINK_SHUTDOWN_BIT = 1;
  localparam int CTRL_SW_MODE_BIT       = 2;
  localparam int CTRL_SW_SHUTDOWN_N_BIT = 3;
  localparam int CTRL_WIDTH             = 4;
  localparam logic [3:0] CTRL_RESET     = 4'h0;

  // status register fields
  localparam int STAT_DRIVERS_ON_BIT  = 0;
  localparam int STAT_PUMP_BIT        = 1;
  localparam int STAT_LINE_VALID_BIT  = 2;
  localparam int STAT_IDLE_BIT        = 3;
  localparam int STAT_SUPPLY_OK_BIT   = 4;
  localparam int STAT_WIDTH           = 5;

  // interrupt event bits, same layout in status, enable and clear
  localparam int EV_DRIVERS_ON_BIT  = 0;
  localparam int EV_DRIVERS_OFF_BIT = 1;
  localparam int EV_IDLE_BIT        = 2;
  localparam int EV_VALID_BIT       = 3;
  localparam int EV_WIDTH           = 4;
  localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;

  // inactivity window
  localparam longint unsigned CLK_HZ      = 250_000_000;
  localparam longint unsigned IDLE_TIME_S = 30;
  localparam longint unsigned IDLE_CYCLES = IDLE_TIME_S * CLK_HZ;
  localparam int IDLE_CNT_WIDTH           = 36;

  typedef enum logic [1:0] {
    DRV_OFF     = 2'b00,
    DRV_PUMPING = 2'b01,
    DRV_ON      = 2'b10
  } drv_state_t;

endpackage

// *** logic/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] change
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;
  logic [WIDTH-1:0] next_change;

  initial begin
    if (WIDTH < 1) $error("pin_sync needs at least one bit");
  end

  // a bit moves only once stages two and three agree
  always_comb begin
    next_level = level;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) next_level[i] = stage2[i];
    end
    next_change = next_level ^ level;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
      change <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
      change <= next_change;
    end
  end

endmodule

`default_nettype wire

// *** testbench/line_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none

module line_far_end #(
  parameter int SUPPLY_DELAY = 6
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       pump_en,
  input  wire logic [2:0] toggle_req,
  output logic            neg_supply_ok,
  output logic [2:0]      rx_line
);
  int unsigned pump_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // rail needs several cycles of pumping before it is usable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pump_cnt      <= 0;
      neg_supply_ok <= 1'b0;
    end else if (!pump_en) begin
      pump_cnt      <= 0;
      neg_supply_ok <= 1'b0;
    end else if (pump_cnt < SUPPLY_DELAY) begin
      pump_cnt      <= pump_cnt + 1;
    end else begin
      neg_supply_ok <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // remote equipment toggles its lines on request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_line <= 3'h0;
    end else begin
      rx_line <= rx_line ^ toggle_req;
    end
  end
endmodule

`default_nettype wire

// *** testbench/line_power_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module line_power_ctrl_tb;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic [2:0]  rx_in, rx_level_ok, tx_in, rx_out, tx_out, tx_oe, toggle_req;
  logic        force_active_in, force_shutdown_n, neg_supply_ok;
  logic        pump_en, valid_out, irq, e;
  int          error_cnt, total_checks;

  line_power_ctrl #(.IDLE_CYCLES(36'h32), .LANES(3)) uut (
    .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RX_IN(rx_in),
    .RX_LEVEL_OK(rx_level_ok), .TX_IN(tx_in),
    .FORCE_ACTIVE_IN(force_active_in), .FORCE_SHUTDOWN_N(force_shutdown_n),
    .NEG_SUPPLY_OK(neg_supply_ok), .RX_OUT(rx_out), .TX_OUT(tx_out),
    .TX_OE(tx_oe), .PUMP_EN(pump_en), .VALID_OUT(valid_out), .IRQ(irq));

  line_far_end far (
    .clk(clk), .resetn(resetn), .pump_en(pump_en), .toggle_req(toggle_req),
    .neg_supply_ok(neg_supply_ok), .rx_line(rx_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
    d       = prdata;
    e       = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pins(input logic fa, input logic fs, input logic [2:0] lv);
    @(posedge clk);
    force_active_in  <= fa;
    force_shutdown_n <= fs;
    rx_level_ok      <= lv;
  endtask

  task automatic pulse(input logic [2:0] rx, input logic [2:0] tx);
    @(posedge clk);
    toggle_req <= rx;
    tx_in      <= tx_in ^ tx;
    @(posedge clk);
    toggle_req <= 3'h0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // bounded wait; running out ends the run as a mismatch
  task automatic wait_oe(input logic [2:0] exp, input int bound);
    int n;
    n = 0;
    @(negedge clk);
    while (tx_oe !== exp && n < bound) begin
      @(negedge clk);
      n++;
    end
    if (tx_oe !== exp) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // drivers may never be live on an unready negative rail
  always @(negedge clk) begin
    if (resetn === 1'b1 && tx_oe !== 3'h0) begin
      check("supply_ok_with_oe", 32'(neg_supply_ok), 32'h1);
    end
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    error_cnt = 0;
    total_checks = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_level_ok, tx_in, toggle_req, force_active_in} = '0;
    force_shutdown_n = 1'b1;
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    apb(0, line_power_pkg::CTRL_ADDR, 0);
    check("ctrl_reset", d, 32'h0);
    apb(0, line_power_pkg::IRQ_ENABLE_ADDR, 0);
    check("irq_en_reset", d, 32'h0);
    apb(0, 8'h40, 0);
    check("unmapped_data", d, 32'h0);
    check("unmapped_err", 32'(e), 32'h1);
    wait_oe(3'h7, 80);
    for (int i = 0; i < 5; i++) begin
      pulse(3'(i[0] << i % 3), 3'(!i[0] << i % 3));
      idle(40);
      check("auto_recent_edge", 32'(tx_oe), 32'h7);
      check("tx_data", 32'(tx_out), 32'(tx_in ^ 3'h7));
    end
    apb(1, line_power_pkg::IRQ_CLEAR_ADDR, 32'hF);
    apb(1, line_power_pkg::IRQ_ENABLE_ADDR, 32'h6);
    // last edge seen 5 cycles after the pulse; expiry is 50 cycles later
    idle(5);
    check("timer_not_early", 32'(tx_oe), 32'h7);
    wait_oe(3'h0, 100);
    check("auto_idle_off", 32'(pump_en), 32'h0);
    apb(0, line_power_pkg::STATUS_ADDR, 0);
    check("status_idle", 32'(d[3]), 32'h1);
    idle(2);
    check("irq_raised", 32'(irq), 32'h1);
    apb(0, line_power_pkg::IRQ_STATUS_ADDR, 0);
    check("irq_status", d, 32'h6);
    apb(1, line_power_pkg::IRQ_ENABLE_ADDR, 32'h0);
    idle(2);
    check("irq_masked", 32'(irq), 32'h0);
    apb(1, line_power_pkg::IRQ_ENABLE_ADDR, 32'h2);
    idle(2);
    check("irq_unmasked", 32'(irq), 32'h1);
    apb(1, line_power_pkg::IRQ_CLEAR_ADDR, 32'hF);
    idle(2);
    check("irq_cleared", 32'(irq), 32'h0);
    pulse(3'h4, 3'h0);
    wait_oe(3'h7, 60);
    check("edge_wakes", 32'(pump_en), 32'h1);
    pins(1, 1, 0);
    idle(150);
    check("forced_on", 32'(tx_oe), 32'h7);
    pins(1, 0, 0);
    wait_oe(3'h0, 40);
    pulse(3'h2, 3'h0);
    idle(8);
    check("rx_live_off", 32'(rx_out), 32'(rx_in ^ 3'h7));
    pins(1, 0, 3'h2);
    idle(8);
    check("valid_high", 32'(valid_out), 32'h1);
    check("still_off", 32'(tx_oe), 32'h0);
    pins(0, 1, 3'h1);
    apb(1, line_power_pkg::CTRL_ADDR, 32'h1);
    wait_oe(3'h7, 60);
    idle(150);
    check("valid_keeps_on", 32'(tx_oe), 32'h7);
    pins(0, 1, 0);
    wait_oe(3'h0, 150);
    check("valid_low", 32'(valid_out), 32'h0);
    pulse(3'h0, 3'h2);
    wait_oe(3'h7, 60);
    check("edge_keeps_on", 32'(pump_en), 32'h1);
    apb(1, line_power_pkg::CTRL_ADDR, 32'h3);
    wait_oe(3'h0, 20);
    pulse(3'h1, 3'h1);
    idle(10);
    check("edges_ignored", 32'(tx_oe), 32'h0);
    pins(0, 1, 3'h4);
    wait_oe(3'h7, 60);
    check("valid_only_on", 32'(tx_oe), 32'h7);
    pins(0, 0, 0);
    apb(1, line_power_pkg::CTRL_ADDR, 32'hC);
    wait_oe(3'h7, 60);
    idle(150);
    check("sw_on_no_idle", 32'(tx_oe), 32'h7);
    apb(1, line_power_pkg::CTRL_ADDR, 32'h4);
    wait_oe(3'h0, 20);
    check("sw_off", 32'(pump_en), 32'h0);
    apb(1, line_power_pkg::CTRL_ADDR, 32'h0);
    // host ties both pins to one shutdown line
    pins(1, 1, 0);
    wait_oe(3'h7, 60);
    check("tied_high_on", 32'(tx_oe), 32'h7);
    tally_and_finish();
  end
endmodule

`default_nettype wire
